// ==== design/aspi_core.sv ====
// Purpose: full-duplex asynchronous serial port with infrared codec
// Assumes: all inputs synchronous to clock; one register access per strobe
// Notes: registers read one cycle after the read strobe
// Overview of operation
// - Infrared enable routes the pins through the built-in pulse encoder and decoder.
// - Port enable hands pins to the module per pin usage; clear means idle.
// - Stop-in-idle freezes the module while the device is in idle mode.
// - Request pin acts as simplex output when mode bit set, else flow control.
// - Pin usage picks which of CTS, RTS, rate clock are owned; transmit pin follows transmit enable.
// - Wake mode watches receive line: falling edge interrupts, rising edge clears wake.
// - Auto-rate measures the next 55h sync character then clears its own bit.
// - Receive inversion makes low the idle receive level.
// - Rate generator gives four ticks per bit in high speed, else sixteen.
// - Infrared codec only works in the sixteen-tick mode.
// - Format field selects nine bits, eight odd, eight even or eight plain.
// - Stop select adds a second stop bit to each transmitted data frame; break frames keep one stop bit.
// - Transmit interrupt fires per transfer, on buffer emptied, or all done.
// - Transmit inversion sets idle pin level, reversed when infrared is on.
// - Break request sends start, twelve zeros, stop, then clears itself.
// - Clearing transmit enable aborts, flushes the buffer and releases the pin.
// - Buffer full flags no room; shifter empty needs buffer empty too, resets one.
// - Receive interrupt fires at four, at three, or on every stored character.
// - Address detect in nine-bit mode keeps only characters with bit nine set.
// - Parity and framing flags describe the character at the receive head.
// - Overflow sets overrun; software clearing it flushes buffer and receive shifter.
// - Data available while buffer holds data; receiver idle shows no reception.
// - Both data buffers are four-entry first-in first-out queues.
// - Reading receive data advances the queue with its own error flags.
// - Writing the divisor clears the rate timer at once.
`timescale 1ns/1ps
module aspi_core import aspi_pkg::*; #(
	parameter int DEPTH = 4
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [ASPI_AW-1:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [15:0] reg_rdata,
	input wire logic idle_mode,
	input wire logic sleep_mode,
	input wire logic serial_in_pin,
	input wire logic clear_to_send_pin_n,
	output logic serial_out_pin,
	output logic serial_out_own,
	output logic request_to_send_pin_n,
	output logic request_to_send_own,
	output logic rate_clock_out_pin,
	output logic tx_irq,
	output logic rx_irq,
	output logic wake_irq
);
	localparam int PW = $clog2(DEPTH);
	if (DEPTH < 4 || (1 << PW) != DEPTH) begin : g_depth_check
		$error("DEPTH must be a power of two, at least 4");
	end

	logic [15:0] mode_q, stat_q, div_q, brg_cnt_q, rdata_q;
	logic tick_q;
	logic [8:0] tx_mem [DEPTH];
	logic [10:0] rx_mem [DEPTH];
	logic [PW:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
	logic tx_busy_q, tx_brk_frame_q, tx_line_q;
	logic [15:0] tx_sh_q;
	logic [4:0] tx_left_q;
	logic [3:0] tx_sub_q, rx_sub_q, ir_hold_q;
	aspi_rx_state_t rx_st_q;
	logic [3:0] rx_idx_q;
	logic [9:0] rx_sh_q;
	logic rx_q, rx_prev_q, wake_seen_q, overrun_error_q, brk_done;
	logic [2:0] ab_edges_q;
	logic [19:0] ab_cnt_q;

	wire en = mode_q[ASPI_M_EN];
	wire run = en && !(mode_q[ASPI_M_SIDL] && idle_mode);
	wire high_speed_rate = mode_q[ASPI_M_HIGH_SPEED_RATE];
	wire ir_on = mode_q[ASPI_M_INFRARED_CODEC_ENABLE] && !high_speed_rate;
	wire [1:0] uen = mode_q[ASPI_M_UEN+:2];
	wire [1:0] fmt = mode_q[ASPI_M_FMT+:2];
	wire auto_rate_measure = mode_q[ASPI_M_AUTO_RATE_MEASURE];
	wire [3:0] os_last = high_speed_rate ? ASPI_OS_HI : ASPI_OS_STD;
	wire txen = stat_q[ASPI_S_TXEN];
	wire [1:0] txisel = {stat_q[ASPI_S_TXIS1], stat_q[ASPI_S_TXIS0]};
	wire [1:0] rxisel = stat_q[ASPI_S_RXIS+:2];

	wire wr_mode = reg_write && reg_addr == ASPI_OFS_MODE;
	wire wr_stat = reg_write && reg_addr == ASPI_OFS_STAT;
	wire wr_txd = reg_write && reg_addr == ASPI_OFS_TXD;
	wire wr_div = reg_write && reg_addr == ASPI_OFS_DIV;
	wire rd_rxd = reg_read && reg_addr == ASPI_OFS_RXD;

	// FIFO levels
	wire [PW:0] tx_cnt = tx_wp_q - tx_rp_q;
	wire [PW:0] rx_cnt = rx_wp_q - rx_rp_q;
	wire tx_full = tx_cnt == (PW+1)'(DEPTH);
	wire tx_empty = tx_cnt == '0;
	wire rx_full = rx_cnt == (PW+1)'(DEPTH);
	wire rx_avail = rx_cnt != '0;
	wire shifter_empty = !tx_busy_q && tx_empty;
	wire [10:0] rx_head = rx_mem[rx_rp_q[PW-1:0]];

	// Software clears overrun by writing zero; a new overflow in that cycle wins
	wire overrun_error_clr = wr_stat && !reg_wdata[ASPI_S_OVERRUN_ERROR] && overrun_error_q;
	logic rx_push, rx_drop;
	wire rx_flush = !en || (overrun_error_clr && !rx_drop);
	wire tx_flush = !en || (wr_stat && !reg_wdata[ASPI_S_TXEN] && txen);

	// Rate generator
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			brg_cnt_q <= '0;
			tick_q <= 1'b0;
		end else if (wr_div || !run) begin
			brg_cnt_q <= '0;
			tick_q <= 1'b0;
		end else begin
			tick_q <= brg_cnt_q == div_q;
			brg_cnt_q <= (brg_cnt_q == div_q) ? '0 : brg_cnt_q + 16'h0001;
		end
	end

	// Auto-rate: 55h gives five falling edges spanning eight bit times
	wire [19:0] ab_shift = high_speed_rate ? (ab_cnt_q >> 5) : (ab_cnt_q >> 7);
	wire ab_done = auto_rate_measure && ab_edges_q == ASPI_AB_EDGES - 3'h1 && rx_prev_q && !rx_q;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ab_edges_q <= '0;
			ab_cnt_q <= '0;
		end else if (!auto_rate_measure || !run) begin
			ab_edges_q <= '0;
			ab_cnt_q <= '0;
		end else begin
			if (rx_prev_q && !rx_q) ab_edges_q <= ab_edges_q + 3'h1;
			// Count from the first edge itself so eight bit times come out whole
			if (ab_edges_q != '0 || (rx_prev_q && !rx_q)) ab_cnt_q <= ab_cnt_q + 20'h00001;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) div_q <= ASPI_RST_DIV;
		else if (wr_div) div_q <= reg_wdata;
		else if (ab_done) div_q <= ab_shift[15:0] - 16'h0001;
	end

	// Mode register; hardware clears wake and auto-rate
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= '0;
			wake_seen_q <= 1'b0;
		end else begin
			if (wr_mode) mode_q <= reg_wdata & ASPI_MODE_WMASK;
			if (ab_done) mode_q[ASPI_M_AUTO_RATE_MEASURE] <= 1'b0;
			if (!(mode_q[ASPI_M_WAKE] && sleep_mode)) wake_seen_q <= 1'b0;
			else if (rx_prev_q && !rx_q) wake_seen_q <= 1'b1;
			else if (wake_seen_q && !rx_prev_q && rx_q) mode_q[ASPI_M_WAKE] <= 1'b0;
		end
	end

	// Status control bits; break request cleared when its frame ends
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stat_q <= '0;
			overrun_error_q <= 1'b0;
		end else begin
			if (wr_stat) stat_q <= {reg_wdata[15:13], 1'b0, reg_wdata[11:10], 2'h0,
				reg_wdata[7:5], 5'h00};
			if (brk_done) stat_q[ASPI_S_BRK] <= 1'b0;
			if (rx_drop) overrun_error_q <= 1'b1;
			else if (overrun_error_clr || !en) overrun_error_q <= 1'b0;
		end
	end

	// Transmit FIFO
	wire tx_push = wr_txd && en && !tx_full;
	wire cts_ok = uen != ASPI_UEN_CTSRTS || !clear_to_send_pin_n;
	wire tx_load = tick_q && txen && !tx_busy_q && !tx_empty && cts_ok && !tx_flush;
	wire [8:0] tx_head = tx_mem[tx_rp_q[PW-1:0]];
	always_ff @(posedge clock) begin
		if (tx_push) tx_mem[tx_wp_q[PW-1:0]] <= reg_wdata[8:0];
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tx_wp_q <= '0;
			tx_rp_q <= '0;
		end else if (tx_flush) begin
			tx_wp_q <= '0;
			tx_rp_q <= '0;
		end else begin
			if (tx_push) tx_wp_q <= tx_wp_q + 1'b1;
			if (tx_load) tx_rp_q <= tx_rp_q + 1'b1;
		end
	end

	// Transmit shifter: frame built with ones above so stop bits shift in free
	logic tx_nine;
	always_comb begin
		unique case (fmt)
			ASPI_FMT_9N: tx_nine = tx_head[8];
			ASPI_FMT_8O: tx_nine = ~^tx_head[7:0];
			ASPI_FMT_8E: tx_nine = ^tx_head[7:0];
			ASPI_FMT_8N: tx_nine = 1'b1;
		endcase
	end
	wire [4:0] tx_bits = 5'h0a + ((fmt != ASPI_FMT_8N) ? 5'h01 : 5'h00)
		+ (mode_q[ASPI_M_STOP] ? 5'h01 : 5'h00);
	wire tx_bit_end = tx_busy_q && tick_q && tx_sub_q == os_last;
	assign brk_done = tx_bit_end && tx_left_q == 5'h01 && tx_brk_frame_q;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tx_busy_q <= 1'b0;
			tx_brk_frame_q <= 1'b0;
			tx_sh_q <= '1;
			tx_left_q <= '0;
			tx_sub_q <= '0;
		end else if (tx_flush) begin
			tx_busy_q <= 1'b0;
			tx_sh_q <= '1;
			tx_sub_q <= '0;
		end else if (tx_load) begin
			tx_busy_q <= 1'b1;
			tx_sub_q <= '0;
			tx_brk_frame_q <= stat_q[ASPI_S_BRK];
			if (stat_q[ASPI_S_BRK]) begin
				tx_sh_q <= ASPI_BRK_FRAME;
				tx_left_q <= ASPI_BRK_BITS;
			end else begin
				tx_sh_q <= {6'h3f, tx_nine, tx_head[7:0], 1'b0};
				tx_left_q <= tx_bits;
			end
		end else if (tx_busy_q && tick_q) begin
			tx_sub_q <= tx_sub_q + 4'h1;
			if (tx_sub_q == os_last) begin
				tx_sub_q <= '0;
				tx_sh_q <= {1'b1, tx_sh_q[15:1]};
				tx_left_q <= tx_left_q - 5'h01;
				if (tx_left_q == 5'h01) tx_busy_q <= 1'b0;
			end
		end
	end

	// Pin drive; infrared zero is a short pulse at bit start
	wire tx_logic = tx_busy_q ? tx_sh_q[0] : 1'b1;
	wire tx_ir = !tx_logic && tx_sub_q < ASPI_IR_PULSE && tx_busy_q;
	wire tx_inv = stat_q[ASPI_S_TXINV];
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tx_line_q <= 1'b1;
			serial_out_pin <= 1'b1;
			serial_out_own <= 1'b0;
			request_to_send_pin_n <= 1'b1;
			request_to_send_own <= 1'b0;
			rate_clock_out_pin <= 1'b0;
		end else begin
			tx_line_q <= tx_logic;
			serial_out_pin <= ir_on ? (tx_ir ^ tx_inv) : (tx_logic ^ tx_inv);
			serial_out_own <= en && txen;
			request_to_send_own <= en && (uen == ASPI_UEN_RTS || uen == ASPI_UEN_CTSRTS);
			// Simplex asserts while sending; flow control while room remains
			request_to_send_pin_n <= mode_q[ASPI_M_REQUEST_PIN_MODE] ? shifter_empty : rx_full;
			rate_clock_out_pin <= en && uen == ASPI_UEN_BCLK && tick_q;
		end
	end

	// Transmit events
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) tx_irq <= 1'b0;
		else begin
			unique case (txisel)
				ASPI_TXI_EACH: tx_irq <= tx_load;
				ASPI_TXI_EMPTY: tx_irq <= tx_load && tx_cnt == (PW+1)'(1);
				ASPI_TXI_DONE: tx_irq <= tx_bit_end && tx_left_q == 5'h01 && tx_empty;
				default: tx_irq <= 1'b0;
			endcase
		end
	end

	// Receive line: inversion, loopback and infrared pulse stretching
	wire rx_raw = (mode_q[ASPI_M_LPBK] ? tx_line_q : serial_in_pin) ^ mode_q[ASPI_M_RECEIVE_POLARITY_INVERT];
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ir_hold_q <= '0;
			rx_q <= 1'b1;
			rx_prev_q <= 1'b1;
		end else begin
			// A low pulse starting by mid-bit marks that bit zero
			if (ir_on && !rx_raw) ir_hold_q <= os_last;
			else if (tick_q && ir_hold_q != '0) ir_hold_q <= ir_hold_q - 4'h1;
			rx_q <= ir_on ? (rx_raw && ir_hold_q == '0) : rx_raw;
			rx_prev_q <= rx_q;
		end
	end

	// Receiver
	wire [3:0] rx_last = (fmt == ASPI_FMT_8N) ? 4'h9 : 4'ha;
	wire rx_sample = rx_st_q == ASPI_RX_BITS && tick_q && rx_sub_q == '0;
	wire rx_stop = rx_sample && rx_idx_q == rx_last;
	logic rx_parity_error;
	always_comb begin
		unique case (fmt)
			ASPI_FMT_8E: rx_parity_error = ^rx_sh_q[9:1];
			ASPI_FMT_8O: rx_parity_error = ~^rx_sh_q[9:1];
			default: rx_parity_error = 1'b0;
		endcase
	end
	wire rx_keep = !(stat_q[ASPI_S_ADDRESS_DETECT_ENABLE] && fmt == ASPI_FMT_9N && !rx_sh_q[9]);
	assign rx_push = rx_stop && rx_keep && !rx_full && !rx_flush;
	assign rx_drop = rx_stop && rx_keep && rx_full;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rx_st_q <= ASPI_RX_IDLE;
			rx_sub_q <= '0;
			rx_idx_q <= '0;
			rx_sh_q <= '0;
		end else if (rx_flush || !run || auto_rate_measure) begin
			rx_st_q <= ASPI_RX_IDLE;
		end else unique case (rx_st_q)
			ASPI_RX_IDLE: if (tick_q && !rx_q) begin
				rx_st_q <= ASPI_RX_BITS;
				rx_sub_q <= os_last >> 1;
				rx_idx_q <= '0;
			end
			ASPI_RX_BITS: if (tick_q) begin
				rx_sub_q <= rx_sub_q - 4'h1;
				if (rx_sub_q == '0) begin
					rx_sub_q <= os_last;
					rx_idx_q <= rx_idx_q + 4'h1;
					if (rx_idx_q != rx_last) rx_sh_q[rx_idx_q] <= rx_q;
					// A start bit gone high by mid-bit was noise
					if ((rx_idx_q == '0 && rx_q) || rx_stop) rx_st_q <= ASPI_RX_IDLE;
				end
			end
		endcase
	end

	// Receive FIFO holds data with its own error flags
	// Bit 8 is data only in nine-bit format; otherwise it is stored as zero
	wire rx_bit8 = fmt == ASPI_FMT_9N && rx_sh_q[9];
	always_ff @(posedge clock) begin
		if (rx_push) rx_mem[rx_wp_q[PW-1:0]] <= {!rx_q, rx_parity_error, rx_bit8, rx_sh_q[8:1]};
	end
	wire rx_pop = rd_rxd && rx_avail;
	wire [PW:0] rx_cnt_new = rx_cnt + (PW+1)'(1);
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rx_wp_q <= '0;
			rx_rp_q <= '0;
			rx_irq <= 1'b0;
		end else begin
			if (rx_flush) begin
				rx_wp_q <= '0;
				rx_rp_q <= '0;
			end else begin
				if (rx_push) rx_wp_q <= rx_wp_q + 1'b1;
				if (rx_pop) rx_rp_q <= rx_rp_q + 1'b1;
			end
			unique case (rxisel)
				ASPI_RXI_FULL: rx_irq <= rx_push && rx_cnt_new == (PW+1)'(4);
				ASPI_RXI_3Q: rx_irq <= rx_push && rx_cnt_new == (PW+1)'(3);
				default: rx_irq <= rx_push;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) wake_irq <= 1'b0;
		else wake_irq <= mode_q[ASPI_M_WAKE] && sleep_mode && rx_prev_q && !rx_q;
	end

	// Register reads; unmapped and write-only words read zero
	wire receiver_idle = rx_st_q == ASPI_RX_IDLE;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) rdata_q <= '0;
		else if (reg_read) begin
			unique case (reg_addr)
				ASPI_OFS_MODE: rdata_q <= mode_q;
				ASPI_OFS_STAT: rdata_q <= {stat_q[15:10], tx_full, shifter_empty, stat_q[7:5],
					receiver_idle, rx_avail && rx_head[9], rx_avail && rx_head[10], overrun_error_q, rx_avail};
				ASPI_OFS_RXD: rdata_q <= rx_avail ? {7'h00, rx_head[8:0]} : '0;
				ASPI_OFS_DIV: rdata_q <= div_q;
				default: rdata_q <= '0;
			endcase
		end
	end
	assign reg_rdata = rdata_q;
endmodule

// ==== design/aspi_pkg.sv ====
// Purpose: constants shared by the serial port design
// Assumes: 16-bit register words on a plain address/strobe port
// Notes: offsets are word indices on the register port
package aspi_pkg;
	localparam int ASPI_AW = 3;
	localparam logic [2:0] ASPI_OFS_MODE = 3'h0;
	localparam logic [2:0] ASPI_OFS_STAT = 3'h1;
	localparam logic [2:0] ASPI_OFS_TXD = 3'h2;
	localparam logic [2:0] ASPI_OFS_RXD = 3'h3;
	localparam logic [2:0] ASPI_OFS_DIV = 3'h4;
	// Mode register fields
	localparam int ASPI_M_EN = 15;
	localparam int ASPI_M_SIDL = 13;
	localparam int ASPI_M_INFRARED_CODEC_ENABLE = 12;
	localparam int ASPI_M_REQUEST_PIN_MODE = 11;
	localparam int ASPI_M_UEN = 8;
	localparam int ASPI_M_WAKE = 7;
	localparam int ASPI_M_LPBK = 6;
	localparam int ASPI_M_AUTO_RATE_MEASURE = 5;
	localparam int ASPI_M_RECEIVE_POLARITY_INVERT = 4;
	localparam int ASPI_M_HIGH_SPEED_RATE = 3;
	localparam int ASPI_M_FMT = 1;
	localparam int ASPI_M_STOP = 0;
	localparam logic [15:0] ASPI_MODE_WMASK = 16'hbbff;
	// Status register fields
	localparam int ASPI_S_TXIS1 = 15;
	localparam int ASPI_S_TXINV = 14;
	localparam int ASPI_S_TXIS0 = 13;
	localparam int ASPI_S_BRK = 11;
	localparam int ASPI_S_TXEN = 10;
	localparam int ASPI_S_RXIS = 6;
	localparam int ASPI_S_ADDRESS_DETECT_ENABLE = 5;
	localparam int ASPI_S_OVERRUN_ERROR = 1;
	// Encodings
	localparam logic [1:0] ASPI_FMT_9N = 2'h3;
	localparam logic [1:0] ASPI_FMT_8O = 2'h2;
	localparam logic [1:0] ASPI_FMT_8E = 2'h1;
	localparam logic [1:0] ASPI_FMT_8N = 2'h0;
	localparam logic [1:0] ASPI_UEN_BCLK = 2'h3;
	localparam logic [1:0] ASPI_UEN_CTSRTS = 2'h2;
	localparam logic [1:0] ASPI_UEN_RTS = 2'h1;
	localparam logic [1:0] ASPI_TXI_EMPTY = 2'h2;
	localparam logic [1:0] ASPI_TXI_DONE = 2'h1;
	localparam logic [1:0] ASPI_TXI_EACH = 2'h0;
	localparam logic [1:0] ASPI_RXI_FULL = 2'h3;
	localparam logic [1:0] ASPI_RXI_3Q = 2'h2;
	localparam logic [3:0] ASPI_OS_STD = 4'hf;
	localparam logic [3:0] ASPI_OS_HI = 4'h3;
	localparam logic [3:0] ASPI_IR_PULSE = 4'h3;
	localparam logic [15:0] ASPI_BRK_FRAME = 16'he000;
	localparam logic [4:0] ASPI_BRK_BITS = 5'h0e;
	localparam logic [2:0] ASPI_AB_EDGES = 3'h5;
	localparam logic [15:0] ASPI_RST_DIV = 16'h0000;
	typedef enum logic [0:0] {ASPI_RX_IDLE = 1'b0, ASPI_RX_BITS = 1'b1} aspi_rx_state_t;
endpackage

// ==== dv/aspi_monitor.sv ====
// Purpose: port-level checks for the serial port core
// Assumes: one clock; register fields shadowed from bus writes
// Notes: shadows copy whole written words, bits that the core clears by itself included
`timescale 1ns/1ps
module aspi_monitor import aspi_pkg::*; #(
	parameter int DEPTH = 4
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [ASPI_AW-1:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [15:0] reg_rdata,
	input wire logic sleep_mode,
	input wire logic serial_out_pin,
	input wire logic serial_out_own,
	input wire logic request_to_send_own,
	input wire logic rate_clock_out_pin,
	input wire logic tx_irq,
	input wire logic rx_irq,
	input wire logic wake_irq
);
	logic [15:0] mode_q;
	logic [15:0] stat_q;
	logic dz_q;
	logic [4:0] gap_q;
	logic gap_ok_q;
	logic [1:0] uen;
	logic plain;
	logic cfg_wr;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	assign uen = mode_q[ASPI_M_UEN+:2];
	assign plain = mode_q[ASPI_M_EN] && stat_q[ASPI_S_TXEN] && !mode_q[ASPI_M_INFRARED_CODEC_ENABLE]
		&& !mode_q[ASPI_M_HIGH_SPEED_RATE] && !stat_q[ASPI_S_TXINV] && dz_q;
	assign cfg_wr = reg_write && (reg_addr == ASPI_OFS_MODE || reg_addr == ASPI_OFS_DIV);
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= 16'h0000;
			stat_q <= 16'h0000;
			dz_q <= 1'b1;
		end else if (reg_write && reg_addr == ASPI_OFS_MODE) begin
			mode_q <= reg_wdata;
		end else if (reg_write && reg_addr == ASPI_OFS_STAT) begin
			stat_q <= reg_wdata;
		end else if (reg_write && reg_addr == ASPI_OFS_DIV) begin
			dz_q <= (reg_wdata == 16'h0000);
		end
	end
	// Tick spacing only trusted when no config write broke the interval
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			gap_q <= 5'h00;
			gap_ok_q <= 1'b0;
		end else begin
			gap_q <= rate_clock_out_pin ? 5'h00 : gap_q + {4'h0, gap_q != 5'h1f};
			gap_ok_q <= rate_clock_out_pin || (gap_ok_q && !cfg_wr);
		end
	end
	sequence low8_s;
		(!serial_out_pin) [*8];
	endsequence
	start_bit_a: assert property ($fell(serial_out_pin) && plain |-> low8_s ##1 low8_s)
		else $error("start bit shorter than sixteen cycles");
	rts_own_a: assert property (mode_q == $past(mode_q) |-> request_to_send_own ==
		(mode_q[ASPI_M_EN] && (uen == ASPI_UEN_RTS || uen == ASPI_UEN_CTSRTS)))
		else $error("request pin ownership wrong");
	tx_own_a: assert property ({mode_q, stat_q} == $past({mode_q, stat_q}) |->
		serial_out_own == (mode_q[ASPI_M_EN] && stat_q[ASPI_S_TXEN]))
		else $error("transmit pin ownership wrong");
	bclk_own_a: assert property (rate_clock_out_pin |->
		$past(mode_q[ASPI_M_EN] && uen == ASPI_UEN_BCLK))
		else $error("rate clock out while not selected");
	bclk_rate_a: assert property (rate_clock_out_pin && gap_ok_q && dz_q
		&& !mode_q[ASPI_M_HIGH_SPEED_RATE] |-> gap_q == 5'h00)
		else $error("rate ticks not one cycle apart at divisor zero");
	wake_sleep_a: assert property (wake_irq |-> $past(sleep_mode))
		else $error("wake interrupt outside sleep");
	tx_pulse_a: assert property (tx_irq |=> !tx_irq)
		else $error("transmit interrupt longer than one cycle");
	rx_pulse_a: assert property (rx_irq |-> ##1 !rx_irq)
		else $error("receive interrupt longer than one cycle");
	rxd_upper_a: assert property ($past(reg_read) && $past(reg_addr) == ASPI_OFS_RXD
		|-> reg_rdata[15:9] == 7'h00)
		else $error("receive data upper bits not zero");
endmodule
bind aspi_core aspi_monitor #(.DEPTH(DEPTH)) u_mon (.clock(clock), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
	.reg_rdata(reg_rdata), .sleep_mode(sleep_mode), .serial_out_pin(serial_out_pin),
	.serial_out_own(serial_out_own), .request_to_send_own(request_to_send_own),
	.rate_clock_out_pin(rate_clock_out_pin), .tx_irq(tx_irq), .rx_irq(rx_irq),
	.wake_irq(wake_irq));

// ==== dv/aspi_peer.sv ====
// Purpose: remote serial terminal facing the port pins
// Assumes: idle line high; frames handed over LSB first with start bit
// Notes: receive sampling fixed at sixteen cycles per bit
`timescale 1ns/1ps
module aspi_peer (
	input wire logic clock,
	input wire logic tx_line,
	output logic rx_line
);
	int bit_cyc = 16;
	initial rx_line = 1'b1;
	task automatic send(input logic [11:0] bits, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clock);
			rx_line <= bits[i];
			repeat (bit_cyc - 1) @(posedge clock);
		end
		@(posedge clock);
		rx_line <= 1'b1;
	endtask
	// Samples mid-bit; a missing start leaves the bits as seen
	task automatic grab(output logic [31:0] bits, input int n);
		int w;
		bits = 32'h0;
		w = 0;
		while (tx_line !== 1'b0 && w < 2000) begin
			@(posedge clock);
			w++;
		end
		repeat (8) @(posedge clock);
		for (int i = 0; i < n; i++) begin
			bits[i] = tx_line;
			repeat (16) @(posedge clock);
		end
	endtask
endmodule

// ==== dv/tb.sv ====
// Purpose: self-checking bench for the serial port core
// Assumes: divisor 0, standard rate, 16 cycles per bit
// Notes: status checked through field masks, except the whole-word check after reset
`timescale 1ns/1ps
module tb import aspi_pkg::*; ();
	logic clock, rst_n, reg_write, reg_read, idle_mode, sleep_mode, cts_n;
	logic [2:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	logic serial_in_pin, serial_out_pin, serial_out_own, rts_n, rts_own, bclk;
	logic tx_irq, rx_irq, wake_irq, last_out;
	int n_errors = 0, comparisons = 0, n_txi = 0, n_rxi = 0, n_wki = 0, n_fall = 0;
	aspi_core #(.DEPTH(4)) dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .idle_mode(idle_mode), .sleep_mode(sleep_mode),
		.serial_in_pin(serial_in_pin), .clear_to_send_pin_n(cts_n),
		.serial_out_pin(serial_out_pin), .serial_out_own(serial_out_own),
		.request_to_send_pin_n(rts_n), .request_to_send_own(rts_own),
		.rate_clock_out_pin(bclk), .tx_irq(tx_irq), .rx_irq(rx_irq), .wake_irq(wake_irq));
	aspi_peer peer (.clock(clock), .tx_line(serial_out_pin), .rx_line(serial_in_pin));
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	always @(posedge clock) begin
		if (tx_irq === 1'b1) n_txi++;
		if (rx_irq === 1'b1) n_rxi++;
		if (wake_irq === 1'b1) n_wki++;
		if (serial_out_pin === 1'b0 && last_out === 1'b1) n_fall++;
		last_out = serial_out_pin;
	end
	task automatic summarize();
		if (n_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	task automatic rc(input logic [2:0] a, input logic [15:0] m, input logic [15:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		@(posedge clock);
		chk(reg_rdata & m, e);
	endtask
	task automatic t_reset();
		rc(ASPI_OFS_MODE, 16'hffff, 16'h0000);
		rc(ASPI_OFS_STAT, 16'hffff, 16'h0110);
		rc(3'h7, 16'hffff, 16'h0000);
		rc(ASPI_OFS_DIV, 16'hffff, 16'h0000);
		wr(ASPI_OFS_MODE, 16'h8300);
		repeat (60) @(posedge clock);
	endtask
	task automatic t_tx();
		logic [31:0] b;
		int t0;
		t0 = n_txi;
		wr(ASPI_OFS_MODE, 16'h8003);
		wr(ASPI_OFS_STAT, 16'h0400);
		fork
			peer.grab(b, 24);
			begin
				wr(ASPI_OFS_TXD, 16'h0055);
				wr(ASPI_OFS_TXD, 16'h0057);
			end
		join
		chk({4'h0, b[11:0]}, {4'h0, 2'b11, ^8'h55, 8'h55, 1'b0});
		chk({4'h0, b[23:12]}, {4'h0, 2'b11, ^8'h57, 8'h57, 1'b0});
		repeat (40) @(posedge clock);
		chk(16'(n_txi - t0), 16'h0002);
		rc(ASPI_OFS_STAT, 16'h0300, 16'h0100);
	endtask
	task automatic t_rx();
		int r0;
		r0 = n_rxi;
		wr(ASPI_OFS_MODE, 16'h8002);
		peer.send({1'b1, ^8'h3c, 8'h3c, 1'b0}, 11);
		peer.send({1'b1, ~^8'h5a, 8'h5a, 1'b0}, 11);
		repeat (16) @(posedge clock);
		rc(ASPI_OFS_STAT, 16'h000f, 16'h0001);
		rc(ASPI_OFS_RXD, 16'hffff, 16'h003c);
		rc(ASPI_OFS_STAT, 16'h000f, 16'h0009);
		rc(ASPI_OFS_RXD, 16'hffff, 16'h005a);
		rc(ASPI_OFS_STAT, 16'h000f, 16'h0000);
		chk(16'(n_rxi - r0), 16'h0002);
	endtask
	task automatic t_ovr();
		int r0;
		r0 = n_rxi;
		wr(ASPI_OFS_MODE, 16'h8000);
		wr(ASPI_OFS_STAT, 16'h0480);
		for (int i = 0; i < 5; i++) peer.send({2'b01, 4'h1, 4'(i), 1'b0}, 10);
		repeat (16) @(posedge clock);
		chk(16'(n_rxi - r0), 16'h0001);
		chk({15'h0000, rts_n}, 16'h0001);
		rc(ASPI_OFS_STAT, 16'h000f, 16'h0003);
		rc(ASPI_OFS_RXD, 16'hffff, 16'h0010);
		wr(ASPI_OFS_STAT, 16'h0480);
		rc(ASPI_OFS_STAT, 16'h000f, 16'h0000);
		rc(ASPI_OFS_RXD, 16'hffff, 16'h0000);
	endtask
	task automatic t_addr();
		wr(ASPI_OFS_MODE, 16'h8006);
		wr(ASPI_OFS_STAT, 16'h0420);
		peer.send({1'b1, 9'h0a5, 1'b0}, 11);
		peer.send({1'b1, 9'h1c3, 1'b0}, 11);
		repeat (16) @(posedge clock);
		rc(ASPI_OFS_RXD, 16'hffff, 16'h01c3);
		rc(ASPI_OFS_STAT, 16'h0001, 16'h0000);
	endtask
	task automatic t_idle();
		@(posedge clock);
		idle_mode <= 1'b1;
		wr(ASPI_OFS_MODE, 16'ha000);
		peer.send({1'b1, 8'h42, 1'b0}, 10);
		repeat (16) @(posedge clock);
		rc(ASPI_OFS_STAT, 16'h0011, 16'h0010);
		idle_mode <= 1'b0;
		peer.send({1'b1, 8'h42, 1'b0}, 10);
		repeat (16) @(posedge clock);
		rc(ASPI_OFS_RXD, 16'hffff, 16'h0042);
	endtask
	task automatic t_flush();
		int f0;
		@(posedge clock);
		cts_n <= 1'b1;
		wr(ASPI_OFS_MODE, 16'h8a00);
		wr(ASPI_OFS_STAT, 16'h0400);
		for (int i = 0; i < 4; i++) wr(ASPI_OFS_TXD, 16'h0030 + 16'(i));
		rc(ASPI_OFS_STAT, 16'h0300, 16'h0200);
		chk({15'h0000, rts_n}, 16'h0000);
		wr(ASPI_OFS_STAT, 16'h4000);
		rc(ASPI_OFS_STAT, 16'h0300, 16'h0100);
		chk({15'h0000, rts_n}, 16'h0001);
		chk({15'h0000, serial_out_pin}, 16'h0000);
		f0 = n_fall;
		wr(ASPI_OFS_STAT, 16'h0400);
		@(posedge clock);
		cts_n <= 1'b0;
		repeat (300) @(posedge clock);
		chk(16'(n_fall - f0), 16'h0000);
	endtask
	task automatic t_auto_rate_measure();
		wr(ASPI_OFS_MODE, 16'h8020);
		peer.bit_cyc = 32;
		peer.send({1'b1, 8'h55, 1'b0}, 10);
		peer.bit_cyc = 16;
		repeat (16) @(posedge clock);
		rc(ASPI_OFS_MODE, 16'h0020, 16'h0000);
		rc(ASPI_OFS_DIV, 16'hffff, 16'h0001);
		wr(ASPI_OFS_DIV, 16'h0000);
	endtask
	task automatic t_wake();
		int w0;
		w0 = n_wki;
		@(posedge clock);
		sleep_mode <= 1'b1;
		wr(ASPI_OFS_MODE, 16'h8080);
		peer.send(12'h000, 1);
		repeat (8) @(posedge clock);
		chk(16'(n_wki - w0), 16'h0001);
		rc(ASPI_OFS_MODE, 16'h0080, 16'h0000);
		sleep_mode <= 1'b0;
	endtask
	initial begin
		repeat (20000) @(posedge clock);
		n_errors++;
		summarize();
	end
	initial begin
		rst_n = 1'b0;
		reg_addr = 3'h0;
		reg_wdata = 16'h0000;
		reg_write = 1'b0;
		reg_read = 1'b0;
		idle_mode = 1'b0;
		sleep_mode = 1'b0;
		cts_n = 1'b0;
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		t_reset();
		t_tx();
		t_rx();
		t_ovr();
		t_addr();
		t_idle();
		t_flush();
		t_auto_rate_measure();
		t_wake();
		summarize();
	end
endmodule
